// *** rtl/mem_page_addr_gen.sv ***
// Program vector, paged RAM and special-function page address generation.
// Sits beside the CPU core on its clock and reset; every request input
// comes from core logic on the same clock, so none is synchronised.
`timescale 1ns/1ps

module mem_page_addr_gen
  import page_addr_pkg::*;
#(
  parameter int IRQ_BITS = 5                                // interrupt index width
) (
  input  wire logic                 clk,                    // CPU clock, 40 MHz
  input  wire logic                 resetn,                 // async reset, active low
  // Program fetch side
  input  wire logic                 fetch_req,              // core wants next code byte
  input  wire logic [15:0]          fetch_pc,               // program counter to fetch
  input  wire logic                 irq_take,               // core vectors to interrupt
  input  wire logic [IRQ_BITS-1:0]  irq_index,              // which interrupt source
  output logic      [15:0]          prog_addr_q,            // 16-bit program address
  output logic                      prog_rd_q,              // one-cycle ROM read strobe
  output logic                      prog_out_of_range_q,    // address beyond on-chip ROM
  // Special-function register port
  input  wire logic                 sfr_wr,                 // SPECIAL_FUNCTION_REGISTER write strobe
  input  wire logic                 sfr_rd,                 // SPECIAL_FUNCTION_REGISTER read strobe
  input  wire logic [7:0]           sfr_addr,               // SPECIAL_FUNCTION_REGISTER direct address
  input  wire logic [7:0]           sfr_wdata,              // SPECIAL_FUNCTION_REGISTER write data
  output logic      [7:0]           sfr_rdata_q,            // read data of this block
  output logic                      sfr_hit_q,              // read hit one of ours
  output logic                      sfr_page_q,             // selected function page
  output logic                      sfr_page1_sel_q,        // decode in page-1 bank
  output logic                      port_data_sel_q,        // port data decode allowed
  output logic                      periph_ctrl_sel_q,      // peripheral decode allowed
  // Data memory side
  input  wire logic                 memory_scheme_select,   // mode bit of cpu_mode_register
  input  wire logic                 data_rd_req,            // internal paged read
  input  wire logic                 data_wr_req,            // internal paged write
  input  wire logic [7:0]           data_addr,              // implied instruction address
  input  wire logic                 xmove_req,              // external-move access
  input  wire logic                 xmove_wr,               // external move is a write
  input  wire logic                 xmove_use_ptr,          // pointer form, else Ri form
  input  wire logic [15:0]          data_pointer_pair,      // 16-bit data pointer
  input  wire logic [7:0]           ri_value,               // R0 or R1 content
  input  wire logic [7:0]           port_two_output_latch,  // port 2 output latch
  output logic      [9:0]           ram_addr_q,             // 10-bit RAM address
  output logic                      ram_rd_q,               // one-cycle RAM read
  output logic                      ram_wr_q,               // one-cycle RAM write
  output logic                      ram_page_invalid_q      // page 7 or above used
);

  import page_addr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Page registers

  logic [7:0]   read_page_register_q;
  logic [7:0]   write_page_register_q;
  logic [7:0]   function_page_register_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      read_page_register_q <= READ_PAGE_RST;
    end else if (sfr_wr && sfr_addr == READ_PAGE_OFS) begin
      read_page_register_q <= sfr_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      write_page_register_q <= WRITE_PAGE_RST;
    end else if (sfr_wr && sfr_addr == WRITE_PAGE_OFS) begin
      write_page_register_q <= sfr_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      function_page_register_q <= FUNC_PAGE_RST;
    end else if (sfr_wr && sfr_addr == FUNC_PAGE_OFS) begin
      function_page_register_q <= sfr_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read-back

  logic [7:0]   sfr_rdata_d;
  logic         sfr_hit_d;

  // Returns stored value whole, so software sees what it wrote
  always_comb begin
    sfr_rdata_d = 8'h00;
    sfr_hit_d   = 1'b0;
    if (sfr_rd) begin
      unique case (sfr_addr)
        READ_PAGE_OFS: begin
          sfr_rdata_d = read_page_register_q;
          sfr_hit_d   = 1'b1;
        end
        WRITE_PAGE_OFS: begin
          sfr_rdata_d = write_page_register_q;
          sfr_hit_d   = 1'b1;
        end
        FUNC_PAGE_OFS: begin
          sfr_rdata_d = function_page_register_q;
          sfr_hit_d   = 1'b1;
        end
        default: begin
          sfr_rdata_d = 8'h00;
          sfr_hit_d   = 1'b0;
        end
      endcase
    end
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata_q <= 8'h00;
      sfr_hit_q   <= 1'b0;
    end else begin
      sfr_rdata_q <= sfr_rdata_d;
      sfr_hit_q   <= sfr_hit_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Special-function page decode

  logic         func_page1;
  logic         sfr_bit_reg;
  logic         sfr_shared_bit;
  logic         page1_sel_d;

  // 01H picks page 1; any other value is treated as page 0
  assign func_page1 = (function_page_register_q == FUNC_PAGE1_VAL);

  // Bit-addressable registers sit on multiples of eight from 80H
  assign sfr_bit_reg    = (sfr_addr >= SFR_BASE) && (sfr_addr[2:0] == 3'h0);
  assign sfr_shared_bit = (sfr_addr == ACC_OFS) || (sfr_addr == B_OFS) || (sfr_addr == PSW_OFS);

  // Only paged bit registers follow the page
  assign page1_sel_d = func_page1 && sfr_bit_reg && !sfr_shared_bit;

  // Decode bank for the register file
  // Port data on page 1, peripherals on page 0
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sfr_page_q        <= 1'b0;
      sfr_page1_sel_q   <= 1'b0;
      port_data_sel_q   <= 1'b0;
      periph_ctrl_sel_q <= 1'b1;
    end else begin
      sfr_page_q        <= func_page1;
      sfr_page1_sel_q   <= page1_sel_d;
      port_data_sel_q   <= func_page1;
      periph_ctrl_sel_q <= !func_page1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Program address

  logic [15:0]  vector_addr;
  logic [15:0]  irq_ext;

  // Vectors at 0003H, 000BH, 0013H, 001BH and onward
  assign irq_ext     = 16'(irq_index);
  assign vector_addr = VECTOR_BASE + (irq_ext << VECTOR_SHIFT);

  // Reset value is the reset vector
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prog_addr_q <= RESET_VECTOR;
    end else if (irq_take) begin
      prog_addr_q <= vector_addr;
    end else if (fetch_req) begin
      prog_addr_q <= fetch_pc;
    end
  end

  // Read strobe only; ROM has no write path
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prog_rd_q           <= 1'b0;
      prog_out_of_range_q <= 1'b0;
    end else if (irq_take) begin
      prog_rd_q           <= 1'b1;
      prog_out_of_range_q <= (vector_addr >= ROM_SIZE);
    end else begin
      prog_rd_q           <= fetch_req;
      prog_out_of_range_q <= fetch_req && (fetch_pc >= ROM_SIZE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Data address

  logic [15:0]  xmove_raw;
  logic [15:0]  xmove_wrapped;
  logic [9:0]   xmove_ram;
  logic [7:0]   paged_sel;
  logic         paged_wr;
  logic [9:0]   paged_ram;
  access_kind_t kind;

  // Pointer form takes all sixteen bits
  // Ri form: port latch bits 1:0 over Ri
  assign xmove_raw = xmove_use_ptr ? data_pointer_pair
                                   : {6'h00, port_two_output_latch[1:0], ri_value};

  // Wrap into the 300h window; constant divisor keeps it a fixed network
  assign xmove_wrapped = xmove_raw % XMOVE_WRAP;

  // Pages 1 to 6 reachable by moves
  // Page is address/128 plus one, offset modulo 128
  assign xmove_ram = xmove_wrapped[9:0] + XMOVE_PAGE_BIAS;

  // Scheme select low is the legacy scheme
  // High: read page serves writes too
  assign paged_wr  = data_wr_req && !data_rd_req;
  assign paged_sel = (paged_wr && !memory_scheme_select) ? write_page_register_q
                                                         : read_page_register_q;

  assign paged_ram = {paged_sel[1:0], data_addr};

  // External moves count only in the alternate scheme; paged access otherwise
  always_comb begin
    if (xmove_req && memory_scheme_select) begin
      kind = ACC_XMOVE;
    end else if (data_rd_req || data_wr_req) begin
      kind = ACC_PAGED;
    end else begin
      kind = ACC_NONE;
    end
  end

  // Page register chooses the working page of paged accesses; moves take it from the address
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ram_addr_q <= 10'h000;
      ram_rd_q   <= 1'b0;
      ram_wr_q   <= 1'b0;
    end else begin
      unique case (kind)
        ACC_XMOVE: begin
          ram_addr_q <= xmove_ram;
          ram_rd_q   <= !xmove_wr;
          ram_wr_q   <= xmove_wr;
        end
        ACC_PAGED: begin
          ram_addr_q <= paged_ram;
          ram_rd_q   <= !paged_wr;
          ram_wr_q   <= paged_wr;
        end
        ACC_NONE: begin
          ram_rd_q   <= 1'b0;
          ram_wr_q   <= 1'b0;
        end
      endcase
    end
  end

  // Flag page 7 and above; software must avoid them
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ram_page_invalid_q <= 1'b0;
    end else begin
      ram_page_invalid_q <= (kind == ACC_PAGED) && (paged_sel >= {5'h00, PAGE_LIMIT});
    end
  end

endmodule // mem_page_addr_gen

// *** rtl/page_addr_pkg.sv ***
// Constants for memory page and vector address generation.
// Assumes a CPU core on the same clock drives every request.
// What this block does
// - First fetch after reset release comes from program address 0000H.
// - Interrupt n vectors to 0003H plus eight times n.
// - Program memory is read only, up to 32K bytes on chip.
// - Program addresses are always carried sixteen bits wide.
// - Memory scheme select low means the legacy paged 1K RAM scheme.
// - Legacy read address is read page low two bits over implied byte.
// - Legacy write address is write page low two bits over implied byte.
// - Paged RAM is four 256-byte windows chosen by page register bits 1:0.
// - Read page register sits at FCH, write page register at FDH.
// - Scheme select high ignores write page; read page serves both.
// - Scheme select high lets external moves reach RAM pages 1 to 6.
// - External move addresses above 2FFh wrap modulo 300h first.
// - Data-pointer external moves take all address bits from the pointer.
// - Register-indirect moves: R0/R1 low byte, port two latch bits 1:0 high.
// - Function page register at FFH: 00H page 0, 01H page 1.
// - Byte-only registers shared; bit registers paged except accumulator, B, status.
// - Port data registers on page 1 only, peripheral control on page 0 only.
package page_addr_pkg;

  // Register offsets in the special-function space
  localparam logic [7:0]  READ_PAGE_OFS     = 8'hFC;
  localparam logic [7:0]  WRITE_PAGE_OFS    = 8'hFD;
  localparam logic [7:0]  FUNC_PAGE_OFS     = 8'hFF;

  // Values after reset
  localparam logic [7:0]  READ_PAGE_RST     = 8'h00;
  localparam logic [7:0]  WRITE_PAGE_RST    = 8'h00;
  localparam logic [7:0]  FUNC_PAGE_RST     = 8'h00;

  // Program memory map
  localparam logic [15:0] RESET_VECTOR      = 16'h0000;
  localparam logic [15:0] VECTOR_BASE       = 16'h0003;
  localparam int          VECTOR_SHIFT      = 3;         // eight-byte spacing
  localparam logic [15:0] ROM_SIZE          = 16'h8000;  // 32K bytes

  // Data memory map
  localparam logic [2:0]  PAGE_LIMIT        = 3'h7;      // first invalid page
  localparam int          PAGE_OFS_BITS     = 7;         // 128 bytes a page
  localparam logic [15:0] XMOVE_WRAP        = 16'h0300;
  localparam logic [9:0]  XMOVE_PAGE_BIAS   = 10'h080;   // one page up

  // Special-function decode
  localparam logic [7:0]  SFR_BASE          = 8'h80;
  localparam logic [7:0]  ACC_OFS           = 8'hE0;
  localparam logic [7:0]  B_OFS             = 8'hF0;
  localparam logic [7:0]  PSW_OFS           = 8'hD0;
  localparam logic [7:0]  FUNC_PAGE0_VAL    = 8'h00;
  localparam logic [7:0]  FUNC_PAGE1_VAL    = 8'h01;

  // Kinds of data access
  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_PAGED,
    ACC_XMOVE
  } access_kind_t;

endpackage

// *** tb/core_model.sv ***
// CPU core stand-in driving every request input of the page block.
// Assumes one shared clock; inputs change at falling edges only.
`timescale 1ns/1ps
module core_model (
  input  wire logic  clk,                                        // CPU clock
  output logic       fetch_req, irq_take, sfr_wr, sfr_rd,        // program and SPECIAL_FUNCTION_REGISTER strobes
  output logic       memory_scheme_select, data_rd_req, data_wr_req, // scheme and paged strobes
  output logic       xmove_req, xmove_wr, xmove_use_ptr,         // external move controls
  output logic [4:0] irq_index,                                  // interrupt number
  output logic [15:0] fetch_pc, data_pointer_pair,               // fetch and pointer values
  output logic [7:0] sfr_addr, sfr_wdata, data_addr, ri_value, port_two_output_latch // operands
);
  // Idle values before the first request
  initial begin
    {fetch_req, irq_take, sfr_wr, sfr_rd, memory_scheme_select, data_rd_req, data_wr_req} = '0;
    {xmove_req, xmove_wr, xmove_use_ptr, irq_index, fetch_pc, data_pointer_pair} = '0;
    {sfr_addr, sfr_wdata, data_addr, ri_value, port_two_output_latch} = '0;
  end
  // One SPECIAL_FUNCTION_REGISTER cycle; released lines show the inverse so stale data never matches
  task automatic sfr_op(input logic w, input logic [7:0] a, d);
    @(negedge clk);
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {w, !w, a, d};
    @(negedge clk);
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {2'b00, ~a, ~d};
  endtask
  // One fetch or vector request
  task automatic prog_op(input logic irq, input logic [4:0] n, input logic [15:0] pc);
    @(negedge clk);
    {irq_take, fetch_req, irq_index, fetch_pc} = {irq, !irq, n, pc};
    @(negedge clk);
    {irq_take, fetch_req, irq_index, fetch_pc} = {2'b00, ~n, ~pc};
  endtask
  // One data access; the scheme bit is a level and stays as left
  task automatic data_op(input logic s, x, w, p, input logic [15:0] ptr, input logic [7:0] a, r, p2);
    @(negedge clk);
    memory_scheme_select = s;
    {xmove_req, xmove_wr, xmove_use_ptr, data_rd_req, data_wr_req} = {x, w, p, !x && !w, !x && w};
    {data_pointer_pair, data_addr, ri_value, port_two_output_latch} = {ptr, a, r, p2};
    @(negedge clk);
    {xmove_req, data_rd_req, data_wr_req} = 3'b000;
    {data_pointer_pair, data_addr, ri_value} = {~ptr, ~a, ~r};
  endtask
endmodule // core_model

// *** tb/mem_page_addr_checker.sv ***
// Port-level assertions for the page address block, bound to it.
// Page registers are shadowed from the SPECIAL_FUNCTION_REGISTER write strobe.
`timescale 1ns/1ps
module mem_page_addr_checker #(
  parameter int IRQ_BITS = 5
) (
  input wire logic clk, resetn, fetch_req, irq_take, prog_rd_q, prog_out_of_range_q, sfr_wr, // strobes
  input wire logic port_data_sel_q, memory_scheme_select, data_rd_req, data_wr_req, xmove_req, // controls
  input wire logic xmove_use_ptr, ram_rd_q, ram_wr_q, ram_page_invalid_q,                 // data side
  input wire logic [IRQ_BITS-1:0] irq_index,                                              // vector index
  input wire logic [15:0] fetch_pc, prog_addr_q, data_pointer_pair,                       // wide values
  input wire logic [7:0] sfr_addr, sfr_wdata, data_addr,                                  // byte values
  input wire logic [9:0] ram_addr_q                                                       // RAM address
);
  logic [7:0] rp_q, wp_q, fp_q; // shadow page registers
  logic [9:0] rd_exp, wr_exp, xm_exp;
  // Shadows follow writes, so checks need no hierarchical peeks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {rp_q, wp_q, fp_q} <= '0;
    end else if (sfr_wr) begin
      if (sfr_addr == 8'hFC) rp_q <= sfr_wdata;
      if (sfr_addr == 8'hFD) wp_q <= sfr_wdata;
      if (sfr_addr == 8'hFF) fp_q <= sfr_wdata;
    end
  end
  assign rd_exp = {rp_q[1:0], data_addr};
  assign wr_exp = {wp_q[1:0], data_addr};
  assign xm_exp = 10'(data_pointer_pair % 16'h0300) + 10'h080;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_first; !$past(resetn) |-> prog_addr_q == 16'h0000; endproperty
  a_first: assert property (p_first) else $error("first address not zero");
  property p_vec; irq_take |=> prog_rd_q && prog_addr_q == 16'h0003 + (16'($past(irq_index)) << 3); endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
  property p_oor; prog_rd_q |-> prog_out_of_range_q == (prog_addr_q >= 16'h8000); endproperty
  a_oor: assert property (p_oor) else $error("range flag wrong");
  property p_fetch; fetch_req && !irq_take |=> prog_rd_q && prog_addr_q == $past(fetch_pc); endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address wrong");
  property p_rd; data_rd_req && !(memory_scheme_select && xmove_req) |=> ram_rd_q && ram_addr_q == $past(rd_exp);
  endproperty
  a_rd: assert property (p_rd) else $error("paged read address wrong");
  property p_wr; !memory_scheme_select && data_wr_req && !data_rd_req |=> ram_wr_q && ram_addr_q == $past(wr_exp);
  endproperty
  a_wr: assert property (p_wr) else $error("legacy write address wrong");
  property p_alt; memory_scheme_select && data_wr_req && !data_rd_req && !xmove_req |=> ram_addr_q == $past(rd_exp);
  endproperty
  a_alt: assert property (p_alt) else $error("alternate write address wrong");
  property p_xm; memory_scheme_select && xmove_req && xmove_use_ptr |=> ram_addr_q == $past(xm_exp); endproperty
  a_xm: assert property (p_xm) else $error("pointer move address wrong");
  property p_inv; data_rd_req && !memory_scheme_select |=> ram_page_invalid_q == ($past(rp_q) >= 8'h07); endproperty
  a_inv: assert property (p_inv) else $error("invalid page flag wrong");
  property p_page; port_data_sel_q == ($past(fp_q) == 8'h01); endproperty
  a_page: assert property (p_page) else $error("port decode page wrong");
endmodule // mem_page_addr_checker
bind mem_page_addr_gen mem_page_addr_checker #(.IRQ_BITS(IRQ_BITS)) chk_u (.clk, .resetn, .fetch_req, .irq_take,
  .prog_rd_q, .prog_out_of_range_q, .sfr_wr, .port_data_sel_q, .memory_scheme_select, .data_rd_req, .data_wr_req,
  .xmove_req, .xmove_use_ptr, .ram_rd_q, .ram_wr_q, .ram_page_invalid_q, .irq_index, .fetch_pc, .prog_addr_q,
  .data_pointer_pair, .sfr_addr, .sfr_wdata, .data_addr, .ram_addr_q);

// *** tb/mem_page_addr_gen_test.sv ***
// Self-checking bench for the page address block.
// Core stand-in issues requests; outputs compared one cycle later.
`timescale 1ns/1ps
module mem_page_addr_gen_test;
  import page_addr_pkg::*;
  logic        clk, resetn, fetch_req, irq_take, sfr_wr, sfr_rd, memory_scheme_select;
  logic        data_rd_req, data_wr_req, xmove_req, xmove_wr, xmove_use_ptr, prog_rd_q, prog_out_of_range_q;
  logic        sfr_hit_q, sfr_page_q, sfr_page1_sel_q, port_data_sel_q, periph_ctrl_sel_q;
  logic        ram_rd_q, ram_wr_q, ram_page_invalid_q;
  logic [4:0]  irq_index;
  logic [9:0]  ram_addr_q;
  logic [15:0] fetch_pc, data_pointer_pair, prog_addr_q;
  logic [7:0]  sfr_addr, sfr_wdata, data_addr, ri_value, port_two_output_latch, sfr_rdata_q;
  logic [15:0] xp [5] = '{16'h0103, 16'h027F, 16'h02FF, 16'h0300, 16'h0305}; // move operands
  logic [9:0]  xa [5] = '{10'h183, 10'h2FF, 10'h37F, 10'h080, 10'h085};      // page*128 + offset
  int          n_errors = 0, num_checks = 0, cycles = 0;
  core_model core_u (.clk, .fetch_req, .irq_take, .sfr_wr, .sfr_rd, .memory_scheme_select, .data_rd_req,
    .data_wr_req, .xmove_req, .xmove_wr, .xmove_use_ptr, .irq_index, .fetch_pc, .data_pointer_pair, .sfr_addr,
    .sfr_wdata, .data_addr, .ri_value, .port_two_output_latch);
  mem_page_addr_gen #(.IRQ_BITS(5)) dut_u (.clk, .resetn, .fetch_req, .fetch_pc, .irq_take, .irq_index,
    .prog_addr_q, .prog_rd_q, .prog_out_of_range_q, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata_q,
    .sfr_hit_q, .sfr_page_q, .sfr_page1_sel_q, .port_data_sel_q, .periph_ctrl_sel_q, .memory_scheme_select,
    .data_rd_req, .data_wr_req, .data_addr, .xmove_req, .xmove_wr, .xmove_use_ptr, .data_pointer_pair,
    .ri_value, .port_two_output_latch, .ram_addr_q, .ram_rd_q, .ram_wr_q, .ram_page_invalid_q);
  //////////////////////////////////////////////////////////////
  task automatic check(input logic [19:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // SPECIAL_FUNCTION_REGISTER read, then hit and data together
  task automatic rd(input logic [7:0] a, input logic [8:0] exp);
    core_u.sfr_op(1'b0, a, 8'h00);
    check({sfr_hit_q, sfr_rdata_q}, exp);
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard; the sequence needs about eighty cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    resetn = 1'b0;
    repeat (10) @(negedge clk);
    check({periph_ctrl_sel_q, prog_addr_q}, {1'b1, RESET_VECTOR});
    resetn = 1'b1;
    rd(8'hFC, 9'h100);
    rd(8'hFD, 9'h100);
    rd(8'hFF, 9'h100);
    // Vector table, eight bytes apart
    for (int n = 0; n < 4; n++) begin
      core_u.prog_op(1'b1, 5'(n), 16'h0000);
      check({prog_rd_q, prog_addr_q}, {1'b1, 16'h0003 + 16'(8 * n)});
    end
    // Edge of the 32K on-chip range
    core_u.prog_op(1'b0, 5'h00, 16'h7FFF);
    check({prog_out_of_range_q, prog_addr_q}, 20'h07FFF);
    core_u.prog_op(1'b0, 5'h00, 16'h8000);
    check({prog_out_of_range_q, prog_addr_q}, 20'h18000);
    // Page registers and an unmapped place
    core_u.sfr_op(1'b1, 8'hFC, 8'h02);
    core_u.sfr_op(1'b1, 8'hFD, 8'h01);
    rd(8'hFC, 9'h102);
    rd(8'hFD, 9'h101);
    rd(8'hFE, 9'h000);
    // Legacy read and write pages, then alternate write on read page
    core_u.data_op(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h45, 8'h00, 8'h00);
    check({ram_rd_q, ram_wr_q, ram_addr_q}, 20'hA45);
    core_u.data_op(1'b0, 1'b0, 1'b1, 1'b0, 16'h0000, 8'h45, 8'h00, 8'h00);
    check({ram_rd_q, ram_wr_q, ram_addr_q}, 20'h545);
    core_u.data_op(1'b1, 1'b0, 1'b1, 1'b0, 16'h0000, 8'h45, 8'h00, 8'h00);
    check({ram_rd_q, ram_wr_q, ram_addr_q}, 20'h645);
    // Pointer moves, wrap and page boundaries
    for (int i = 0; i < 5; i++) begin
      core_u.data_op(1'b1, 1'b1, 1'b0, 1'b1, xp[i], 8'h00, 8'h00, 8'h00);
      check({ram_rd_q, ram_addr_q}, {1'b1, xa[i]});
    end
    // Register-indirect write; latch bits above 1:0 must not leak in
    core_u.data_op(1'b1, 1'b1, 1'b1, 1'b0, 16'h0000, 8'h00, 8'h10, 8'hFE);
    check({ram_wr_q, ram_addr_q}, {1'b1, 10'h290});
    // A move in the legacy scheme is no access at all
    core_u.data_op(1'b0, 1'b1, 1'b1, 1'b0, 16'h0000, 8'h00, 8'h33, 8'h01);
    check({ram_rd_q, ram_wr_q, ram_addr_q}, 20'h290);
    // Reserved page 7 written on purpose, then the top valid page
    core_u.sfr_op(1'b1, 8'hFC, 8'h07);
    core_u.data_op(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h12, 8'h00, 8'h00);
    check({ram_page_invalid_q, ram_addr_q}, {1'b1, 10'h312});
    core_u.sfr_op(1'b1, 8'hFC, 8'h06);
    core_u.data_op(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h12, 8'h00, 8'h00);
    check({ram_page_invalid_q, ram_addr_q}, {1'b0, 10'h212});
    // Function page 1: bit register paged, accumulator and byte register shared
    core_u.sfr_op(1'b1, 8'hFF, 8'h01);
    rd(8'h88, 9'h000);
    check({sfr_page_q, port_data_sel_q, periph_ctrl_sel_q, sfr_page1_sel_q}, 20'hD);
    rd(8'hE0, 9'h000);
    check(sfr_page1_sel_q, 1'b0);
    rd(8'h89, 9'h000);
    check(sfr_page1_sel_q, 1'b0);
    core_u.sfr_op(1'b1, 8'hFF, 8'h00);
    rd(8'h88, 9'h000);
    check({sfr_page_q, port_data_sel_q, periph_ctrl_sel_q, sfr_page1_sel_q}, 20'h2);
    report_and_stop();
  end
endmodule // mem_page_addr_gen_test
